// ===== rtl/ffebm_defines.svh
// Constants for the read-side flag, echo and bus-matching block
`ifndef FFEBM_DEFINES_SVH
`define FFEBM_DEFINES_SVH

// Stored word width and lane width
`define FFEBM_DATA_W 72
`define FFEBM_LANE_W 18

// Buffer depth in 72-bit words
`define FFEBM_DEPTH 16

// Empty offset loaded at master reset
`define FFEBM_AE_OFS_RST 2

// Reset value of the write-side pin synchroniser: resets released, straps low
`define FFEBM_PIN_SYNC_RST 8'hc0

// Bit positions in the write-side pin synchroniser
`define FFEBM_PIN_MRS 7
`define FFEBM_PIN_PRS 6
`define FFEBM_PIN_PFM 5
`define FFEBM_PIN_END 4
`define FFEBM_PIN_BM 3
`define FFEBM_PIN_IW 2
`define FFEBM_PIN_OW 1
`define FFEBM_PIN_FT 0

`endif

// ===== rtl/ffebm_pkg.sv
// Types shared by the read-side flag, echo and bus-matching block
`default_nettype none

package ffebm_pkg;

	// Output bus width fixed at master reset
	typedef enum logic [1:0] {
		FFEBM_W72,
		FFEBM_W36,
		FFEBM_W18
	} ffebm_width_e;

	// Mode straps captured at master reset
	typedef struct packed {
		logic fall_through_mode;
		logic sync_flags;
		logic little;
		ffebm_width_e width;
	} ffebm_cfg_s;

endpackage

`default_nettype wire

// ===== rtl/ffebm_fifo_if.sv
// Carrier between the block and its dual-clock word buffer
`timescale 1ns/1ns
`default_nettype none

interface ffebm_fifo_if #(
	parameter int W = 72,
	parameter int CW = 5
);
	logic wr_valid;
	logic wr_ready;
	logic [W-1:0] wr_data;
	logic [CW-1:0] wr_count;
	logic rd_valid;
	logic rd_ready;
	logic [W-1:0] rd_data;
	logic [CW-1:0] rd_count;

	modport store (input wr_valid, input wr_data, input rd_ready,
		output wr_ready, output wr_count, output rd_valid, output rd_data, output rd_count);
	modport user (output wr_valid, output wr_data, output rd_ready,
		input wr_ready, input wr_count, input rd_valid, input rd_data, input rd_count);
endinterface

`default_nettype wire

// ===== rtl/ffebm_afifo.sv
// Dual-clock word buffer with gray-coded pointers
`timescale 1ns/1ns
`default_nettype none
`include "ffebm_defines.svh"

module ffebm_afifo #(
	parameter int WIDTH = `FFEBM_DATA_W,
	parameter int DEPTH = `FFEBM_DEPTH
) (
	input wire logic wr_clk_i,
	input wire logic wr_rst_i,
	input wire logic rd_clk_i,
	input wire logic rd_rst_i,
	ffebm_fifo_if.store f
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	generate if (DEPTH < 4 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
		$error("Buffer depth must be a power of two, at least 4");
	end endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [CW-1:0] wr_bin, next_wr_bin, wr_gray, rg_s1, rg_s2;
	logic [CW-1:0] rd_bin, next_rd_bin, rd_gray, wg_s1, wg_s2;

	// Gray to binary conversion
	function automatic logic [CW-1:0] g2b(input logic [CW-1:0] g);
		logic [CW-1:0] b;
		b = '0;
		for (int i = 0; i < CW; i++) begin
			b[i] = ^(g >> i);
		end
		return b;
	endfunction

	// Flags and counts seen from each side
	assign f.wr_ready = wr_gray != {~rg_s2[CW-1:CW-2], rg_s2[CW-3:0]};
	assign f.rd_valid = rd_gray != wg_s2;
	assign f.wr_count = wr_bin - g2b(rg_s2);
	assign f.rd_count = g2b(wg_s2) - rd_bin;
	assign f.rd_data = mem[rd_bin[AW-1:0]];

	// Pointer advance
	always_comb begin
		next_wr_bin = wr_bin + CW'(f.wr_valid & f.wr_ready);
		next_rd_bin = rd_bin + CW'(f.rd_ready & f.rd_valid);
	end

	// Write side: storage, pointer, read pointer crossing
	always_ff @(posedge wr_clk_i) begin
		if (f.wr_valid && f.wr_ready) begin
			mem[wr_bin[AW-1:0]] <= f.wr_data;
		end
		if (wr_rst_i) begin
			wr_bin <= '0;
			wr_gray <= '0;
			rg_s1 <= '0;
			rg_s2 <= '0;
		end else begin
			wr_bin <= next_wr_bin;
			wr_gray <= next_wr_bin ^ (next_wr_bin >> 1);
			rg_s1 <= rd_gray;
			rg_s2 <= rg_s1;
		end
	end

	// Read side: pointer, write pointer crossing
	always_ff @(posedge rd_clk_i) begin
		if (rd_rst_i) begin
			rd_bin <= '0;
			rd_gray <= '0;
			wg_s1 <= '0;
			wg_s2 <= '0;
		end else begin
			rd_bin <= next_rd_bin;
			rd_gray <= next_rd_bin ^ (next_rd_bin >> 1);
			wg_s1 <= wr_gray;
			wg_s2 <= wg_s1;
		end
	end
endmodule

`default_nettype wire

// ===== rtl/ffebm_serial_load.sv
// Serial loader for the empty offset
`timescale 1ns/1ns
`default_nettype none
`include "ffebm_defines.svh"

module ffebm_serial_load #(
	parameter int OFS_W = 5,
	parameter int RST_VAL = `FFEBM_AE_OFS_RST
) (
	input wire logic sys_clk_i,
	input wire logic load_rst_i,
	input wire logic sclk_i,
	input wire logic sen_n_i,
	input wire logic sdi_i,
	output logic [OFS_W-1:0] offset_o
);
	generate if (OFS_W < 2 || RST_VAL >= (1 << OFS_W)) begin : g_chk
		$error("Offset width too small for its reset value");
	end endgenerate

	logic [2:0] s1, s2;
	logic sclk_d;
	logic [OFS_W-1:0] next_offset;

	// Pin synchronisers plus serial clock history
	always_ff @(posedge sys_clk_i) begin
		s1 <= {sclk_i, sen_n_i, sdi_i};
		s2 <= s1;
		sclk_d <= s2[2];
	end

	// Shift in, most significant bit first, on a serial clock rise
	always_comb begin
		next_offset = offset_o;
		if (load_rst_i) begin
			next_offset = OFS_W'(RST_VAL);
		end else if (s2[2] && !sclk_d && !s2[1]) begin
			next_offset = {offset_o[OFS_W-2:0], s2[0]}; // [RULE_11]
		end
	end

	always_ff @(posedge sys_clk_i) begin
		offset_o <= next_offset;
	end
endmodule

`default_nettype wire

// ===== rtl/ffebm_top.sv
// Read-side flags, echo outputs and bus matching of a dual-clock FIFO
`timescale 1ns/1ns
`default_nettype none
`include "ffebm_defines.svh"

// Summary of operation
// [RULE_01] Standard: almost-empty low at count <= offset
// [RULE_02] Fall-through: low at count <= offset plus one; with async timing the code releases it only above offset plus two
// [RULE_03] Async timing: low on read, high on write
// [RULE_04] Sync timing: flag updates on read clock only
// [RULE_05] Half-full low when write passes half depth
// [RULE_06] Half-full high once count drops to half
// [RULE_07] Standard: half-full after half plus one writes
// [RULE_08] Fall-through: half-full after half plus two writes
// [RULE_09] Echo clock toggles every read clock cycle
// [RULE_10] Echo enable low on each real read
// [RULE_11] Serial offset bit taken on clock while enabled
// [RULE_12] Output width 72, 36 or 18, from bit zero
// [RULE_13] Four lanes; 72 to 72 passes straight
// [RULE_14] 72 to 36: two reads, endian lane order
// [RULE_15] 72 to 18: four reads, endian lane order
// [RULE_16] Echo enable high when no word leaves
// [RULE_17] Flag timing strap captured at master reset
// [RULE_18] Endian strap captured at master reset
// [RULE_19] Width straps captured at master reset
module ffebm_top import ffebm_pkg::*; #(
	parameter int DEPTH = `FFEBM_DEPTH
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic rd_clk_i,
	input wire logic master_reset_n_i,
	input wire logic partial_reset_n_i,
	input wire logic wr_en_n_i,
	input wire logic [`FFEBM_DATA_W-1:0] wr_data_i,
	output logic wr_ready_o,
	input wire logic read_enable_n_i,
	input wire logic read_chip_select_n_i,
	output logic [`FFEBM_DATA_W-1:0] data_out_o,
	output logic echo_read_clock_o,
	output logic echo_read_enable_n_o,
	output logic almost_empty_flag_n_o,
	output logic half_full_flag_n_o,
	input wire logic serial_prog_clock_i,
	input wire logic serial_prog_enable_n_i,
	input wire logic serial_prog_in_i,
	input wire logic flag_timing_mode_sel_i,
	input wire logic endian_select_n_i,
	input wire logic bus_match_sel_i,
	input wire logic input_width_sel_i,
	input wire logic output_width_sel_i,
	input wire logic fall_through_mode_i
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam int TW = CW + 1;
	localparam int DW = `FFEBM_DATA_W;
	localparam int LW = `FFEBM_LANE_W;
	localparam int CFG_W = $bits(ffebm_cfg_s);
	localparam int XW = 2 + CW + CFG_W;

	generate if (DEPTH < 4 || (1 << AW) != DEPTH || DW != 4 * LW) begin : g_chk
		$error("Depth must be a power of two of at least 4 and data four lanes wide");
	end endgenerate

	// Strap decode into an output width
	function automatic ffebm_width_e width_decode(input logic bm, input logic iw, input logic ow);
		ffebm_width_e r;
		r = FFEBM_W72;
		if (bm && !iw) begin
			r = ow ? FFEBM_W18 : FFEBM_W36;
		end
		return r;
	endfunction

	// Index of the last beat of one stored word
	function automatic logic [1:0] last_beat(input ffebm_width_e wd);
		logic [1:0] r;
		r = 2'h0;
		if (wd == FFEBM_W36) begin
			r = 2'h1;
		end else if (wd == FFEBM_W18) begin
			r = 2'h3;
		end
		return r;
	endfunction

	// Lane selection for one beat; unused upper bits read zero
	function automatic logic [DW-1:0] lane_pick(input logic [DW-1:0] w, input logic [1:0] idx,
		input ffebm_width_e wd, input logic little);
		logic [1:0] k;
		logic [DW-1:0] r;
		r = '0;
		k = little ? ~idx : idx;
		unique case (wd)
			FFEBM_W36: r[2*LW-1:0] = (idx[0] ^ little) ? w[2*LW-1:0] : w[DW-1:2*LW]; // [RULE_14]
			FFEBM_W18: r[LW-1:0] = w[DW-1-LW*k -: LW]; // [RULE_15]
			default: r = w; // [RULE_13]
		endcase
		return r; // [RULE_12]
	endfunction

	// ---------------- Write clock domain ----------------
	logic [7:0] w_pin_s1, w_pin_s2;
	logic mrs_act, clr_act, clr_w;
	ffebm_cfg_s cfg, next_cfg;
	logic [CW-1:0] offset;
	logic next_half_full_n;
	logic r_rst; // Clear as seen on the read clock, also resets the buffer's read side
	logic ae_hi_w, next_ae_hi_w;
	logic next_wr_ready;

	ffebm_fifo_if #(.W(DW), .CW(CW)) ff ();

	// Reset and strap pin synchronisers
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			w_pin_s1 <= `FFEBM_PIN_SYNC_RST;
			w_pin_s2 <= `FFEBM_PIN_SYNC_RST;
		end else begin
			w_pin_s1 <= {master_reset_n_i, partial_reset_n_i, flag_timing_mode_sel_i, endian_select_n_i,
				bus_match_sel_i, input_width_sel_i, output_width_sel_i, fall_through_mode_i};
			w_pin_s2 <= w_pin_s1;
		end
	end

	// Master reset sets modes; either reset clears data
	assign mrs_act = rst_i | ~w_pin_s2[`FFEBM_PIN_MRS];
	assign clr_act = mrs_act | ~w_pin_s2[`FFEBM_PIN_PRS];

	// Straps follow the pins while master reset is held
	always_comb begin
		next_cfg = cfg;
		if (mrs_act) begin
			next_cfg.sync_flags = w_pin_s2[`FFEBM_PIN_PFM]; // [RULE_17]
			next_cfg.little = w_pin_s2[`FFEBM_PIN_END]; // [RULE_18]
			next_cfg.width = width_decode(w_pin_s2[`FFEBM_PIN_BM], w_pin_s2[`FFEBM_PIN_IW],
				w_pin_s2[`FFEBM_PIN_OW]); // [RULE_19]
			next_cfg.fall_through_mode = w_pin_s2[`FFEBM_PIN_FT];
		end
	end

	// Empty offset, kept over a partial reset
	ffebm_serial_load #(.OFS_W(CW), .RST_VAL(`FFEBM_AE_OFS_RST)) u_load (
		.sys_clk_i(sys_clk_i),
		.load_rst_i(mrs_act),
		.sclk_i(serial_prog_clock_i),
		.sen_n_i(serial_prog_enable_n_i),
		.sdi_i(serial_prog_in_i),
		.offset_o(offset)
	);

	// Writes are stalled by a full buffer or a reset
	assign ff.wr_valid = ~wr_en_n_i & ~clr_act;
	assign ff.wr_data = wr_data_i;

	// Half-full and almost-empty release, judged on the write clock
	always_comb begin
		next_wr_ready = ff.wr_ready & ~clr_act;
		next_half_full_n = 1'b1;
		next_ae_hi_w = 1'b0;
		if (!clr_act) begin
			// Stored count excludes a word already taken into the output register
			next_half_full_n = ~(ff.wr_count > CW'(DEPTH / 2)); // [RULE_05] [RULE_06] [RULE_07] [RULE_08]
			next_ae_hi_w = TW'(ff.wr_count) > (TW'(offset) + TW'(cfg.fall_through_mode)); // [RULE_03]
		end
	end

	always_ff @(posedge sys_clk_i) begin
		cfg <= next_cfg;
		clr_w <= clr_act;
		wr_ready_o <= next_wr_ready;
		half_full_flag_n_o <= next_half_full_n;
		ae_hi_w <= next_ae_hi_w;
	end

	// Dual-clock word buffer
	ffebm_afifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_fifo (
		.wr_clk_i(sys_clk_i),
		.wr_rst_i(clr_act),
		.rd_clk_i(rd_clk_i),
		.rd_rst_i(r_rst),
		.f(ff.store)
	);

	// ---------------- Read clock domain ----------------
	logic [XW-1:0] x_s1, x_s2;
	logic [1:0] r_pin_s1, r_pin_s2;
	logic r_ae_hi;
	logic [CW-1:0] r_ofs;
	ffebm_cfg_s rc;
	logic rd_req, last;
	logic [TW-1:0] total, thr;
	logic [DW-1:0] hold, next_hold;
	logic pres, next_pres;
	logic [1:0] beat, next_beat;
	logic [DW-1:0] next_q;
	logic next_echo_read_enable_n_n, next_echo_read_clock, next_ae_n;

	// Quasi-static crossing of reset, modes, offset and release level
	always_ff @(posedge rd_clk_i) begin
		x_s1 <= {clr_w, ae_hi_w, offset, cfg};
		x_s2 <= x_s1;
		r_pin_s1 <= {read_enable_n_i, read_chip_select_n_i};
		r_pin_s2 <= r_pin_s1;
	end

	assign r_rst = x_s2[XW-1];
	assign r_ae_hi = x_s2[XW-2];
	assign r_ofs = x_s2[CFG_W +: CW];
	assign rc = ffebm_cfg_s'(x_s2[CFG_W-1:0]);
	assign rd_req = ~r_pin_s2[1] & ~r_pin_s2[0];
	assign last = beat == last_beat(rc.width);

	// Read sequencing: beats of the held word, then the next word
	always_comb begin
		next_hold = hold;
		next_pres = pres;
		next_beat = beat;
		next_q = data_out_o;
		next_echo_read_enable_n_n = 1'b1; // [RULE_16]
		ff.rd_ready = 1'b0;
		if (r_rst) begin
			next_pres = 1'b0;
			next_beat = 2'h0;
			next_q = '0;
		end else if (rd_req && pres && !last) begin
			next_beat = 2'(beat + 2'h1);
			next_q = lane_pick(hold, 2'(beat + 2'h1), rc.width, rc.little);
			next_echo_read_enable_n_n = 1'b0; // [RULE_10]
		end else if ((rd_req || (rc.fall_through_mode && !pres)) && ff.rd_valid) begin
			// Fall-through preloads an idle output register without a read
			ff.rd_ready = 1'b1;
			next_hold = ff.rd_data;
			next_pres = 1'b1;
			next_beat = 2'h0;
			next_q = lane_pick(ff.rd_data, 2'h0, rc.width, rc.little);
			next_echo_read_enable_n_n = ~(rd_req && (pres || !rc.fall_through_mode)); // [RULE_10]
		end else if (rd_req && pres && rc.fall_through_mode) begin
			// Last presented word taken; no new word appears, so no echo pulse
			next_pres = 1'b0;
			next_echo_read_enable_n_n = 1'b1; // [RULE_16]
		end
	end

	// Almost-empty flag
	always_comb begin
		total = TW'(ff.rd_count) + TW'(rc.fall_through_mode & pres);
		thr = TW'(r_ofs) + TW'(rc.fall_through_mode); // [RULE_01] [RULE_02]
		next_echo_read_clock = ~echo_read_clock_o; // [RULE_09]
		next_ae_n = almost_empty_flag_n_o;
		if (r_rst) begin
			next_ae_n = 1'b0;
			next_echo_read_clock = 1'b0;
		end else if (rc.sync_flags) begin
			next_ae_n = ~(total <= thr); // [RULE_04]
		end else if (total <= thr) begin
			next_ae_n = 1'b0; // [RULE_03]
		end else if (r_ae_hi) begin
			next_ae_n = 1'b1; // [RULE_03]
		end
	end

	always_ff @(posedge rd_clk_i) begin
		hold <= next_hold;
		pres <= next_pres;
		beat <= next_beat;
		data_out_o <= next_q;
		echo_read_enable_n_o <= next_echo_read_enable_n_n;
		echo_read_clock_o <= next_echo_read_clock;
		almost_empty_flag_n_o <= next_ae_n;
	end
endmodule

`default_nettype wire

// ===== dv/ffebm_top_monitor.sv
// Assertion checker for the flag, echo and bus-matching block
`timescale 1ns/1ns
`default_nettype none
`include "ffebm_defines.svh"
module ffebm_top_monitor #(
	parameter int DEPTH = `FFEBM_DEPTH
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic rd_clk_i,
	input wire logic master_reset_n_i,
	input wire logic partial_reset_n_i,
	input wire logic wr_en_n_i,
	input wire logic read_enable_n_i,
	input wire logic read_chip_select_n_i,
	input wire logic [`FFEBM_DATA_W-1:0] data_out_o,
	input wire logic echo_read_clock_o,
	input wire logic echo_read_enable_n_o,
	input wire logic almost_empty_flag_n_o,
	input wire logic half_full_flag_n_o,
	input wire logic bus_match_sel_i,
	input wire logic input_width_sel_i,
	input wire logic output_width_sel_i,
	input wire logic fall_through_mode_i
);
	logic pend;
	logic [3:0] cfg; // bm, iw, ow, fall-through
	logic [4:0] rd_up;
	// Strap levels seen on the first edge after a reset ends
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !master_reset_n_i) begin
			pend <= 1'b1;
		end else if (pend) begin
			pend <= 1'b0;
			cfg <= {bus_match_sel_i, input_width_sel_i, output_width_sel_i, fall_through_mode_i};
		end
	end
	// Read clock edges since the last reset, saturating
	always_ff @(posedge rd_clk_i) begin
		if (rst_i || !master_reset_n_i || !partial_reset_n_i) begin
			rd_up <= 5'h00;
		end else if (rd_up != 5'h1f) begin
			rd_up <= rd_up + 5'h01;
		end
	end
	// Read request pins idle, and seen a few edges back
	sequence req_gap;
		(read_enable_n_i || read_chip_select_n_i) [*5];
	endsequence
	sequence req_seen;
		$past(!read_enable_n_i && !read_chip_select_n_i, 2) || $past(!read_enable_n_i && !read_chip_select_n_i, 3)
			|| $past(!read_enable_n_i && !read_chip_select_n_i, 4);
	endsequence
	chk_echo_clock_runs: assert property (@(posedge rd_clk_i) disable iff (rst_i)
		rd_up == 5'h1f |-> echo_read_clock_o != $past(echo_read_clock_o)) else $error("echo clock stalled");
	chk_echo_read_enable_n_has_req: assert property (@(posedge rd_clk_i) disable iff (rst_i)
		!echo_read_enable_n_o |-> req_seen) else $error("echo enable low without request");
	chk_echo_read_enable_n_idle_high: assert property (@(posedge rd_clk_i) disable iff (rst_i)
		req_gap |-> echo_read_enable_n_o) else $error("echo enable low while idle");
	chk_data_needs_echo: assert property (@(posedge rd_clk_i) disable iff (rst_i)
		rd_up == 5'h1f && !cfg[0] && $changed(data_out_o) |-> !echo_read_enable_n_o)
		else $error("data moved without echo enable");
	chk_hf_reset_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(!master_reset_n_i) [*6] |-> half_full_flag_n_o) else $error("half-full low in reset");
	chk_ae_reset_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(!master_reset_n_i) [*8] |-> !almost_empty_flag_n_o) else $error("almost-empty high when empty");
	chk_hf_fall_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$fell(half_full_flag_n_o) |-> $past(!wr_en_n_i) || $past(!wr_en_n_i, 2)) else $error("half-full fell without write");
	chk_width36_zero: assert property (@(posedge rd_clk_i) disable iff (rst_i)
		cfg[3:1] == 3'h4 |-> data_out_o[71:36] == 36'h0) else $error("upper bits set at width 36");
	chk_width18_zero: assert property (@(posedge rd_clk_i) disable iff (rst_i)
		cfg[3:1] == 3'h5 |-> data_out_o[71:18] == 54'h0) else $error("upper bits set at width 18");
endmodule
bind ffebm_top ffebm_top_monitor #(.DEPTH(DEPTH)) ffebm_top_monitor_i (.sys_clk_i, .rst_i, .rd_clk_i,
	.master_reset_n_i, .partial_reset_n_i, .wr_en_n_i, .read_enable_n_i, .read_chip_select_n_i, .data_out_o,
	.echo_read_clock_o, .echo_read_enable_n_o, .almost_empty_flag_n_o, .half_full_flag_n_o, .bus_match_sel_i,
	.input_width_sel_i, .output_width_sel_i, .fall_through_mode_i);
`default_nettype wire

// ===== dv/ffebm_reader.sv
// Reading device model at the block's read port
`timescale 1ns/1ns
`default_nettype none
`include "ffebm_defines.svh"
module ffebm_reader (
	input wire logic rd_clk_i,
	input wire logic echo_read_enable_n_i,
	input wire logic [`FFEBM_DATA_W-1:0] data_out_i,
	output logic read_enable_n_o,
	output logic read_chip_select_n_o
);
	logic [`FFEBM_DATA_W-1:0] beats[$];
	initial begin
		read_enable_n_o = 1'b1;
		read_chip_select_n_o = 1'b1;
	end
	// Keep every beat that the echo enable marks
	always @(negedge rd_clk_i) begin
		if (echo_read_enable_n_i === 1'b0) begin
			beats.push_back(data_out_i);
		end
	end
	// One-cycle reads; a slow reader drops chip select between them
	task automatic read_n(input int k, input logic slow);
		repeat (k) begin
			@(negedge rd_clk_i);
			read_enable_n_o = 1'b0;
			read_chip_select_n_o = 1'b0;
			if (slow) begin
				@(negedge rd_clk_i);
				read_chip_select_n_o = 1'b1;
			end
		end
		@(negedge rd_clk_i);
		read_enable_n_o = 1'b1;
		read_chip_select_n_o = 1'b1;
	endtask
endmodule
`default_nettype wire

// ===== dv/fifo_flags_echo_bus_match_test.sv
// Self-checking bench for the flag, echo and bus-matching block
`timescale 1ns/1ns
`default_nettype none
`include "ffebm_defines.svh"
module fifo_flags_echo_bus_match_test;
	localparam int D = 16;
	logic sys_clk = 1'b0, rd_clk = 1'b0, rst = 1'b1, mr_n = 1'b1, pr_n = 1'b1, wen_n = 1'b1;
	logic flag_timing_mode_sel = 1'b0, sclk = 1'b0, sen_n = 1'b1, sdi = 1'b0;
	logic [4:0] st = 5'h00; // bm, iw, ow, endian, fall-through
	logic [71:0] wdata = 72'h0, dout;
	logic wrdy, echo_read_clock, echo_read_enable_n_n, ae_n, hf_n, ren_n, rcs_n;
	int n_mismatch = 0, n_checks = 0, nb, o, base;
	// Rows: expected beats per word beside the strap levels
	logic [7:0] rows [11] = '{8'h20, 8'h22, 8'h24, 8'h38, 8'h50, 8'h52, 8'h94, 8'h96, 8'h53, 8'h95, 8'h21};
	// Clocks, unrelated in phase
	initial forever #50 sys_clk = ~sys_clk;
	initial begin
		#7;
		forever #15 rd_clk = ~rd_clk;
	end
	ffebm_top #(.DEPTH(D)) ffebm_top_i (.sys_clk_i(sys_clk), .rst_i(rst), .rd_clk_i(rd_clk), .master_reset_n_i(mr_n),
		.partial_reset_n_i(pr_n), .wr_en_n_i(wen_n), .wr_data_i(wdata), .wr_ready_o(wrdy), .read_enable_n_i(ren_n),
		.read_chip_select_n_i(rcs_n), .data_out_o(dout), .echo_read_clock_o(echo_read_clock), .echo_read_enable_n_o(echo_read_enable_n_n),
		.almost_empty_flag_n_o(ae_n), .half_full_flag_n_o(hf_n), .serial_prog_clock_i(sclk),
		.serial_prog_enable_n_i(sen_n), .serial_prog_in_i(sdi), .flag_timing_mode_sel_i(flag_timing_mode_sel),
		.endian_select_n_i(st[1]), .bus_match_sel_i(st[4]), .input_width_sel_i(st[3]), .output_width_sel_i(st[2]),
		.fall_through_mode_i(st[0]));
	ffebm_reader ffebm_reader_i (.rd_clk_i(rd_clk), .echo_read_enable_n_i(echo_read_enable_n_n), .data_out_i(dout),
		.read_enable_n_o(ren_n), .read_chip_select_n_o(rcs_n));
	task automatic check(input logic [71:0] seen, input logic [71:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic fe(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	function automatic logic [71:0] word(input int i);
		return {18'h3a000 + 18'(i), 18'h2b000 + 18'(i), 18'h1c000 + 18'(i), 18'h0d000 + 18'(i)};
	endfunction
	// Beat k of a word for nb beats per word and the chosen order
	function automatic logic [71:0] beat(input logic [71:0] w, input int nb, input logic le, input int k);
		int j;
		j = le ? nb - 1 - k : k;
		if (nb == 1) return w;
		if (nb == 2) return {36'h0, w[71 - 36 * j -: 36]};
		return {54'h0, w[71 - 18 * j -: 18]};
	endfunction
	// Master reset; strap pins then move, the captured modes must not
	task automatic mreset(input logic [4:0] s, input logic pf);
		st = s;
		flag_timing_mode_sel = pf;
		fe(2);
		mr_n = 1'b0;
		fe(8);
		mr_n = 1'b1;
		fe(6);
		st = ~s;
		fe(6);
	endtask
	task automatic wr_n(input int k, input int b);
		wen_n = 1'b0;
		for (int i = 0; i < k; i++) begin
			wdata = word(b + i);
			fe(1);
		end
		wen_n = 1'b1;
	endtask
	// Writes one by one, then reads down across both thresholds
	task automatic flags(input logic ft, input int thr);
		for (int k = 1; k <= D / 2 + 2; k++) begin
			wr_n(1, k);
			fe(8);
			check(72'(ae_n), 72'(k > thr));
			check(72'(hf_n), 72'(k <= D / 2 + int'(ft)));
		end
		ffebm_reader_i.read_n(2, 1'b0);
		fe(8);
		check(72'(hf_n), 72'h1);
		ffebm_reader_i.read_n(D / 2 - thr - 1, 1'b1);
		fe(8);
		check(72'(ae_n), 72'h1);
		ffebm_reader_i.read_n(1, 1'b0);
		fe(8);
		check(72'(ae_n), 72'h0);
	endtask
	// Watchdog
	initial begin
		#3000000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		fe(16);
		rst = 1'b0;
		fe(6);
		check(dout, 72'h0);
		check(72'({hf_n, ae_n, echo_read_enable_n_n}), 72'h5);
		// Bus matching and echo enable per row; reads past the end find nothing
		for (int r = 0; r < 11; r++) begin
			mreset(rows[r][4:0], r[0]);
			nb = int'(rows[r][7:5]);
			o = int'(rows[r][0]);
			base = r * 4;
			ffebm_reader_i.beats.delete();
			wr_n(2, base);
			fe(10);
			if (o == 1) check(dout, beat(word(base), nb, rows[r][1], 0));
			ffebm_reader_i.read_n(2 * nb + 3, r[1]);
			fe(4);
			check(72'(ffebm_reader_i.beats.size()), 72'(2 * nb - o));
			for (int k = o; k < 2 * nb && k - o < ffebm_reader_i.beats.size(); k++) begin
				check(ffebm_reader_i.beats[k - o], beat(word(base + k / nb), nb, rows[r][1], k % nb));
			end
		end
		// Fill until refused, drain with a slow reader
		mreset(5'h00, 1'b1);
		ffebm_reader_i.beats.delete();
		wr_n(D + 1, 64);
		check(72'(wrdy), 72'h0);
		ffebm_reader_i.read_n(D + 2, 1'b1);
		fe(4);
		check(72'(ffebm_reader_i.beats.size()), 72'(D));
		for (int k = 0; k < D && k < ffebm_reader_i.beats.size(); k++) begin
			check(ffebm_reader_i.beats[k], word(64 + k));
		end
		mreset(5'h00, 1'b0);
		flags(1'b0, 2);
		// Serial offset 5, after one clock with the enable high that must be ignored
		for (int i = 5; i >= 0; i--) begin
			sen_n = (i == 5);
			sdi = (i == 5) ? 1'b1 : 1'(5'h05 >> i);
			fe(5);
			sclk = 1'b1;
			fe(5);
			sclk = 1'b0;
		end
		sen_n = 1'b1;
		pr_n = 1'b0;
		fe(8);
		pr_n = 1'b1;
		fe(6);
		flags(1'b0, 5);
		mreset(5'h01, 1'b1);
		flags(1'b1, 3);
		print_verdict();
	end
endmodule
`default_nettype wire
